// file: hw/iwd_pkg.sv
// constants for the independent watchdog timer
package iwd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [31:0] KEY_ENTRY_ADDR = 32'h4000_1000;
    localparam logic [31:0] SETUP_ADDR     = 32'h4000_1004;

    // ----------------------------------------------------------------
    // key words
    // ----------------------------------------------------------------
    localparam logic [15:0] KEY_RELOAD = 16'hAAAA;
    localparam logic [15:0] KEY_UNLOCK = 16'h5555;
    localparam logic [15:0] KEY_START  = 16'hCCCC;
    localparam logic [15:0] KEY_READ   = 16'h0000;

    // ----------------------------------------------------------------
    // setup register field positions
    // ----------------------------------------------------------------
    localparam int RUN_BIT    = 31;
    localparam int LOCK_BIT   = 30;
    localparam int STOP_BIT   = 29;
    localparam int CNT_MSB    = 27;
    localparam int CNT_LSB    = 16;
    localparam int UPD_BIT    = 15;
    localparam int DIV_MSB    = 14;
    localparam int DIV_LSB    = 12;
    localparam int RELOAD_MSB = 11;
    localparam int RELOAD_LSB = 0;

    // ----------------------------------------------------------------
    // reset values and divider
    // ----------------------------------------------------------------
    localparam logic [11:0] COUNT_RESET  = 12'hFFF;
    localparam logic [11:0] RELOAD_RESET = 12'hFFF;
    localparam logic [2:0]  DIV_RESET    = 3'h0;
    localparam logic        LOCK_RESET   = 1'h1;
    localparam logic        STOP_RESET   = 1'h0;
    localparam logic [8:0]  DIV_BASE     = 9'h004;

endpackage

// file: hw/iwd_watchdog.sv
// independent watchdog timer: key register, setup register, prescaler and down-counter
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
// Summary of operation
// - writing the reload key copies the reload value into the down-counter.
// - a running counter that reaches zero without reload raises a system reset.
// - writing the unlock key lifts write protection on the protected fields.
// - writing the start key starts counting, and the hardware option runs it regardless.
// - the key register takes a 16-bit key in its low half and always reads zero.
// - the top setup bit reads 1 while the watchdog runs and 0 while it is off.
// - a lock flag, 1 after reset, blocks changes to protected fields while it reads 1.
// - a protected stop-enable bit, reset to 0, turns the stop switch on or off.
// - the current 12-bit counter is readable in the count field and resets to all ones.
// - an update flag reads 1 when the setup register has been updated.
// - a protected 3-bit divider select divides the slow clock by 4 up to 512.
// - a protected 12-bit reload field, reset to all ones, holds the reload value.
// - after each reload the counter decrements from the loaded value.
// - the timeout follows from the reload value and the selected division.
// - counter and prescaler advance from the dedicated low-speed oscillator only.
module iwd_watchdog
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        low_speed_osc,
    input  wire logic        hw_watchdog_sel,
    input  wire logic        stop_request,
    output logic             watchdog_reset
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [2:0]  osc_sync;
    logic [1:0]  hw_sync;
    logic [1:0]  stop_sync;
    logic        osc_edge;
    logic [8:0]  div_count;
    logic [9:0]  div_limit;
    logic [8:0]  div_last;
    logic        div_tick;
    logic        watchdog_running_flag;
    logic        write_lock;
    logic        stop_enable;
    logic        config_update_flag;
    logic [2:0]  tick_divider_select;
    logic [11:0] reload_value;
    logic [11:0] count;
    logic        key_wr;
    logic        setup_wr;
    logic        key_reload;
    logic        key_unlock;
    logic        key_start;
    logic        counting;
    logic        expire;
    logic [31:0] next_rdata;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign key_wr     = reg_wr && (reg_addr == iwd_pkg::KEY_ENTRY_ADDR);
    assign setup_wr   = reg_wr && (reg_addr == iwd_pkg::SETUP_ADDR);
    // other key values decode to nothing
    assign key_reload = key_wr && (reg_wdata[15:0] == iwd_pkg::KEY_RELOAD);
    assign key_unlock = key_wr && (reg_wdata[15:0] == iwd_pkg::KEY_UNLOCK);
    assign key_start  = key_wr && (reg_wdata[15:0] == iwd_pkg::KEY_START);

    // ----------------------------------------------------------------
    // slow oscillator and strap synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            osc_sync  <= 3'h0;
            hw_sync   <= 2'h0;
            stop_sync <= 2'h0;
        end
        else
        begin
            osc_sync  <= {osc_sync[1:0], low_speed_osc};
            hw_sync   <= {hw_sync[0], hw_watchdog_sel};
            stop_sync <= {stop_sync[0], stop_request};
        end
    end

    // rising edge of the slow oscillator, seen after two stages
    assign osc_edge = osc_sync[1] && !osc_sync[2];

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // divide by 4 shifted left by the select code; ten bits so that 512 fits
    assign div_limit = 10'(iwd_pkg::DIV_BASE) << tick_divider_select;
    assign div_last  = 9'(div_limit - 10'h001);
    assign div_tick  = osc_edge && (div_count == div_last);
    // stop switch freezes counting while a stop is requested
    assign counting  = watchdog_running_flag && !(stop_enable && stop_sync[1]);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_count <= 9'h000;
        end
        else if (key_reload || key_start)
        begin
            div_count <= 9'h000;
        end
        else if (counting && osc_edge)
        begin
            if (div_tick)
            begin
                div_count <= 9'h000;
            end
            else
            begin
                div_count <= div_count + 9'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            watchdog_running_flag <= 1'h0;
        end
        else if (key_start || hw_sync[1])
        begin
            watchdog_running_flag <= 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // write protection
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            write_lock <= iwd_pkg::LOCK_RESET;
        end
        else if (key_unlock)
        begin
            write_lock <= 1'h0;
        end
        else if (key_reload || key_start)
        begin
            write_lock <= 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // protected setup fields
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stop_enable         <= iwd_pkg::STOP_RESET;
            tick_divider_select <= iwd_pkg::DIV_RESET;
            reload_value        <= iwd_pkg::RELOAD_RESET;
        end
        else if (setup_wr && !write_lock)
        begin
            stop_enable         <= reg_wdata[iwd_pkg::STOP_BIT];
            tick_divider_select <= reg_wdata[iwd_pkg::DIV_MSB:iwd_pkg::DIV_LSB];
            reload_value        <= reg_wdata[iwd_pkg::RELOAD_MSB:iwd_pkg::RELOAD_LSB];
        end
    end

    // update flag: set by an accepted setup write, cleared by reload or start key
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            config_update_flag <= 1'h0;
        end
        else if (setup_wr && !write_lock)
        begin
            config_update_flag <= 1'h1;
        end
        else if (key_reload || key_start)
        begin
            config_update_flag <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // down-counter and reset generation
    // ----------------------------------------------------------------
    assign expire = counting && div_tick && (count == 12'h000);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= iwd_pkg::COUNT_RESET;
        end
        else if (key_reload || expire)
        begin
            count <= reload_value;
        end
        else if (counting && div_tick)
        begin
            count <= count - 12'h001;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            watchdog_reset <= 1'h0;
        end
        else
        begin
            watchdog_reset <= expire;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (reg_rd && (reg_addr == iwd_pkg::KEY_ENTRY_ADDR))
        begin
            next_rdata = {16'h0000, iwd_pkg::KEY_READ};
        end
        else if (reg_rd && (reg_addr == iwd_pkg::SETUP_ADDR))
        begin
            next_rdata[iwd_pkg::RUN_BIT]                    = watchdog_running_flag;
            next_rdata[iwd_pkg::LOCK_BIT]                   = write_lock;
            next_rdata[iwd_pkg::STOP_BIT]                   = stop_enable;
            next_rdata[iwd_pkg::CNT_MSB:iwd_pkg::CNT_LSB]   = count;
            next_rdata[iwd_pkg::UPD_BIT]                    = config_update_flag;
            next_rdata[iwd_pkg::DIV_MSB:iwd_pkg::DIV_LSB]   = tick_divider_select;
            next_rdata[iwd_pkg::RELOAD_MSB:iwd_pkg::RELOAD_LSB] = reload_value;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// file: verification/iwd_watchdog_props.sv
// assertions on the register port and reset output of the watchdog
`timescale 1ns/1ns
module iwd_watchdog_props
(
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        hw_watchdog_sel,
    input wire logic        watchdog_reset
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic run_seen;
    wire  rd_cfg = reg_rd && reg_addr == iwd_pkg::SETUP_ADDR;
    wire  rd_key = reg_rd && reg_addr == iwd_pkg::KEY_ENTRY_ADDR;
    wire  key_wr = reg_wr && reg_addr == iwd_pkg::KEY_ENTRY_ADDR;

    // ------------------------------------------------------------
    // remembers that a setup read showed the watchdog running
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            run_seen <= 1'b0;
        else if (reg_rdata[31])
            run_seen <= 1'b1;
    end

    sequence s_unlock; key_wr && reg_wdata[15:0] == iwd_pkg::KEY_UNLOCK; endsequence
    sequence s_reload; key_wr && reg_wdata[15:0] == iwd_pkg::KEY_RELOAD; endsequence
    sequence s_cfg_wr; reg_wr && reg_addr == iwd_pkg::SETUP_ADDR; endsequence

    a_idle_read_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_key_read_zero: assert property (rd_key |=> reg_rdata == 32'h0)
        else $error("key register read not zero");
    a_unmapped_zero: assert property (reg_rd && !rd_cfg && !rd_key |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_unlock_clears: assert property (s_unlock ##2 rd_cfg |=> !reg_rdata[30])
        else $error("lock still set after unlock key");
    a_reload_relocks: assert property (s_reload ##2 rd_cfg |=> reg_rdata[30] && !reg_rdata[15])
        else $error("reload key left lock or update wrong");
    a_cfg_write_lands: assert property (s_cfg_wr ##2 rd_cfg |=> reg_rdata[30] ||
        (reg_rdata[15] && reg_rdata[11:0] == $past(reg_wdata[11:0], 3)))
        else $error("unlocked setup write not taken");
    a_reset_one_cycle: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("reset pulse longer than one cycle");
    a_run_sticky: assert property (rd_cfg && run_seen |=> reg_rdata[31])
        else $error("running flag dropped");
    a_hw_start: assert property (hw_watchdog_sel [*8] ##0 rd_cfg |=> reg_rdata[31])
        else $error("hardware option did not start the watchdog");
endmodule

bind iwd_watchdog iwd_watchdog_props u_props
    (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hw_watchdog_sel, .watchdog_reset);

// file: verification/iwd_watchdog_tb.sv
// self-checking bench for the independent watchdog timer
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module iwd_watchdog_tb;
    localparam logic [31:0] KEY = iwd_pkg::KEY_ENTRY_ADDR;
    localparam logic [31:0] CFG = iwd_pkg::SETUP_ADDR;
    logic        mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        low_speed_osc = 1'b0, hw_watchdog_sel = 1'b0, stop_request = 1'b0;
    logic        watchdog_reset;
    logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, m, x;
    logic [31:0] rs = 32'hED5066D1;
    int          error_cnt = 0, n_tests = 0, cyc = 0, e, r, seen;

    always #25 mclk = ~mclk;

    iwd_watchdog DUT (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .low_speed_osc, .hw_watchdog_sel, .stop_request, .watchdog_reset);

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // ------------------------------------------------------------
    // bus tasks; m mirrors the setup register
    // ------------------------------------------------------------
    task automatic wr(input logic [31:0] a, d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        if (a == CFG && !m[30])
            m[29:0] = {d[29], 1'b0, m[27:16], 1'b1, d[14:0]};
        if (a != KEY)
            return;
        if (d[15:0] == iwd_pkg::KEY_UNLOCK)
            m[30] = 1'b0;
        if (d[15:0] == iwd_pkg::KEY_RELOAD)
            m[27:16] = m[11:0];
        if (d[15:0] == iwd_pkg::KEY_START)
            m[31] = 1'b1;
        if (d[15:0] == iwd_pkg::KEY_RELOAD || d[15:0] == iwd_pkg::KEY_START)
            {m[30], m[15]} = 2'b10;
    endtask

    task automatic rd(input logic [31:0] a, ex);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", ex, reg_rdata)
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // one pass per divider code, ending in a timeout
    // ------------------------------------------------------------
    initial
    begin
        for (int d = 0; d < 8; d++)
        begin
            hw_watchdog_sel <= 1'b0;
            reset_n <= 1'b0;
            repeat (5) @(posedge mclk);
            reset_n <= 1'b1;
            m = 32'h4FFF0FFF;
            rd(CFG, m);
            rd(KEY, 32'h0);
            rd(CFG + 32'h8, 32'h0);
            wr(CFG, rnd());
            rd(CFG, m);
            x = rnd();
            wr(KEY, {x[31:16], 4'h1, x[11:0]});
            rd(CFG, m);
            wr(KEY, {x[31:16], iwd_pkg::KEY_UNLOCK});
            rd(CFG, m);
            r = x[1:0];
            wr(CFG, {x[31:30], x[2], x[28:15], d[2:0], 10'h0, x[1:0]});
            stop_request <= ~x[2];
            rd(CFG, m);
            wr(KEY, {x[31:16], iwd_pkg::KEY_RELOAD});
            rd(CFG, m);
            if (d == 7)
            begin
                hw_watchdog_sel <= 1'b1;
                m[31] = 1'b1;
                repeat (8) @(posedge mclk);
            end
            else
                wr(KEY, {16'h0, iwd_pkg::KEY_START});
            rd(CFG, m);
            seen = 0;
            e = 0;
            while (seen == 0)
            begin
                e++;
                for (int k = 0; k < 8; k++)
                begin
                    @(posedge mclk);
                    low_speed_osc <= (k < 4);
                    #1;
                    if (watchdog_reset === 1'b1)
                        seen = 1;
                end
            end
            `CHK("timeout edges", (r + 1) * (4 << d), e)
        end
        final_report();
    end
endmodule
